// ### src/line_transmit_fetch_sequencer.sv
// Functional notes
// R1 - on entry fetch selected count; zero low 15 bits switches table or ends
// R2 - go set with no count loaded never sends a character
// R3 - non-zero count: current address drives a memory read into read data
// R4 - message-protocol bit 06 with mode 000 skips control byte fetch
// R5 - control byte fetched only after an error-free character fetch
// R6 - control address is base plus mode in 08-10 over character in 00-07
// R7 - character copy kept in write data for sending and check accumulation
// R8 - error-free control byte bits 05-07 become mode bits 00-02
// R9 - command bits tested 01, 02, 03; bit 01 sends DLE first
// R10 - control bit 02 sets progress bit 00 to send check next
// R11 - control bit 03 folds character into accumulated check register 0110
// R12 - after decode, data-not-available sets underrun, line state bit 03
// R13 - synchronous transmitter flags data-not-available when starved
// R14 - asynchronous transmitter never flags data-not-available
// R15 - saved character loaded with a 300 ns transmitter strobe
// R16 - line state bit 07 picks table; count and address incremented
// R17 - incremented count zero switches table or ends transmission
// R18 - memory fetch waits a fixed 20 us before non-existent memory error
// R19 - software loads counts that count upward to zero
//
// Local design decisions: the strobed register port and the address map.
module line_transmit_fetch_sequencer (
	// clock and reset
	input  wire logic                 core_clk_in,
	input  wire logic                 rst_n_in,
	// register port
	input  wire line_tx_pkg::reg_req_t reg_req_in,
	output logic [15:0]               reg_rdata_out,
	// service request from the line scanner
	input  wire logic                 service_req_in,
	// bus-master memory read
	output line_tx_pkg::mem_req_t     mem_req_out,
	input  wire line_tx_pkg::mem_rsp_t mem_rsp_in,
	// line transmitter
	input  wire logic                 data_not_available_in,
	input  wire logic                 async_line_in,
	output line_tx_pkg::tx_load_t     tx_load_out,
	// status
	output logic                      busy_out,
	output logic                      irq_out
);

	// ----------------------------------------------------------------
	// types and functions
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE, S_ENTRY, S_CHAR_REQ, S_CTRL_REQ, S_DECODE,
		S_DLE_STROBE, S_ACCUM, S_DNA, S_STROBE, S_ADVANCE
	} seq_state_t;

	// true when the low count bits are exhausted
	function automatic logic count_empty(input logic [15:0] c);
		count_empty = (c[line_tx_pkg::COUNT_LOW_W-1:0] == 15'h0000);
	endfunction : count_empty

	// one byte through a reflected crc
	function automatic logic [15:0] crc_byte(input logic [15:0] acc,
		input logic [7:0] ch, input logic [15:0] poly);
		logic [15:0] r;
		r = acc ^ {8'h00, ch};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ poly) : (r >> 1);
		end
		crc_byte = r;
	endfunction : crc_byte

	// check network selected by the protocol control bits
	function automatic logic [15:0] check_combine(input logic [15:0] acc,
		input logic [7:0] ch, input logic [1:0] ctl);
		case (ctl)
			line_tx_pkg::CHECK_LRC:
				check_combine = {8'h00, acc[7:0] ^ ch};
			line_tx_pkg::CHECK_CRC16:
				check_combine = crc_byte(acc, ch, line_tx_pkg::POLY_CRC16);
			default:
				check_combine = crc_byte(acc, ch, line_tx_pkg::POLY_CCITT);
		endcase
	endfunction : check_combine

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	seq_state_t  state_ff;
	seq_state_t  nxt_state;
	logic [15:0] prin_addr_ff;
	logic [15:0] prin_count_ff;
	logic [15:0] alt_addr_ff;
	logic [15:0] alt_count_ff;
	logic [15:0] ctrl_base_ff;
	logic [15:0] protocol_ff;
	logic [15:0] accum_check_ff;
	logic [2:0]  mode_ff;
	logic        send_check_next_ff;
	logic [7:0]  line_state_ff;
	logic [5:0]  int_status_ff;
	logic [5:0]  int_mask_ff;
	logic [7:0]  memory_read_data_reg_ff;
	logic [7:0]  memory_write_data_reg_ff;
	logic [7:0]  ctrl_byte_ff;
	logic [15:0] mem_addr_ff;
	logic [11:0] cnt_ff;
	logic [7:0]  tx_char_ff;
	logic        tx_strobe_ff;
	logic [15:0] rdata_ff;

	// ----------------------------------------------------------------
	// decode of the sequencer condition
	// ----------------------------------------------------------------
	logic        sel_alt;
	logic [15:0] sel_count;
	logic [15:0] other_count;
	logic [15:0] sel_addr;
	logic [15:0] inc_count;
	logic        wr_hit;
	logic        mem_done;
	logic        mem_timeout;
	logic        skip_ctrl;
	logic [15:0] ctrl_addr;
	logic [5:0]  ev;

	assign sel_alt     = line_state_ff[line_tx_pkg::LS_TABLE];
	assign sel_count   = sel_alt ? alt_count_ff : prin_count_ff;
	assign other_count = sel_alt ? prin_count_ff : alt_count_ff;
	assign sel_addr    = sel_alt ? alt_addr_ff : prin_addr_ff;
	assign inc_count   = sel_count + 16'h0001;
	assign wr_hit      = reg_req_in.wr;
	assign mem_done    = mem_rsp_in.ack;
	assign mem_timeout = (cnt_ff ==
		12'(line_tx_pkg::NXM_CYCLES - 1));                  // [R18]
	assign skip_ctrl   = protocol_ff[line_tx_pkg::PROTO_MSG_TX]
		&& (mode_ff == line_tx_pkg::MODE_PLAIN);            // [R4]
	assign ctrl_addr   = ctrl_base_ff
		+ {5'h00, mode_ff, memory_read_data_reg_ff};        // [R6]

	// ----------------------------------------------------------------
	// sequencer state machine
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE: begin
				if (service_req_in && line_state_ff[line_tx_pkg::LS_GO]) begin
					nxt_state = S_ENTRY;
				end
			end
			S_ENTRY: begin
				// empty count never reaches a fetch
				if (count_empty(sel_count)) begin             // [R1] [R2]
					nxt_state = count_empty(other_count) ? S_IDLE : S_ENTRY;
				end else begin
					nxt_state = S_CHAR_REQ;                   // [R3]
				end
			end
			S_CHAR_REQ: begin
				if (mem_done) begin
					if (mem_rsp_in.parity_err) begin
						nxt_state = S_IDLE;
					end else if (skip_ctrl) begin
						nxt_state = S_ACCUM;                  // [R4]
					end else begin
						nxt_state = S_CTRL_REQ;               // [R5]
					end
				end else if (mem_timeout) begin
					nxt_state = S_IDLE;                       // [R5] [R18]
				end
			end
			S_CTRL_REQ: begin
				if (mem_done) begin
					nxt_state = mem_rsp_in.parity_err ? S_IDLE : S_DECODE;
				end else if (mem_timeout) begin
					nxt_state = S_IDLE;                       // [R18]
				end
			end
			S_DECODE: begin
				// commands taken in order 01, 02, 03
				if (ctrl_byte_ff[line_tx_pkg::CB_SEND_DLE]) begin
					nxt_state = S_DLE_STROBE;                 // [R9]
				end else if (ctrl_byte_ff[line_tx_pkg::CB_INCLUDE]) begin
					nxt_state = S_ACCUM;                      // [R11]
				end else begin
					nxt_state = S_DNA;
				end
			end
			S_DLE_STROBE: begin
				if (cnt_ff == 12'(line_tx_pkg::STROBE_CYCLES - 1)) begin
					nxt_state = ctrl_byte_ff[line_tx_pkg::CB_INCLUDE]
						? S_ACCUM : S_DNA;                    // [R9]
				end
			end
			S_ACCUM: nxt_state = S_DNA;
			S_DNA: nxt_state = S_STROBE;
			S_STROBE: begin
				if (cnt_ff == 12'(line_tx_pkg::STROBE_CYCLES - 1)) begin
					nxt_state = S_ADVANCE;                    // [R15]
				end
			end
			S_ADVANCE: nxt_state = S_IDLE;
			default: nxt_state = S_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff <= S_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// shared wait and strobe counter, cleared on every state change
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_ff <= 12'h000;
		end else if (nxt_state != state_ff) begin
			cnt_ff <= 12'h000;
		end else if (state_ff != S_IDLE) begin
			cnt_ff <= cnt_ff + 12'h001;
		end
	end

	// ----------------------------------------------------------------
	// memory fetch
	// ----------------------------------------------------------------
	// address, read data and the saved character copy
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mem_addr_ff              <= 16'h0000;
			memory_read_data_reg_ff  <= 8'h00;
			memory_write_data_reg_ff <= 8'h00;
			ctrl_byte_ff             <= 8'h00;
		end else begin
			if (state_ff == S_ENTRY) begin
				mem_addr_ff <= sel_addr;                      // [R3]
			end
			if (state_ff == S_CHAR_REQ && mem_done) begin
				memory_read_data_reg_ff  <= mem_rsp_in.data;  // [R3]
				memory_write_data_reg_ff <= mem_rsp_in.data;  // [R7]
				mem_addr_ff <= ctrl_base_ff
					+ {5'h00, mode_ff, mem_rsp_in.data};      // [R6]
			end
			if (state_ff == S_CTRL_REQ && mem_done) begin
				ctrl_byte_ff <= mem_rsp_in.data;
			end
		end
	end

	assign mem_req_out.valid = (state_ff == S_CHAR_REQ)
		|| (state_ff == S_CTRL_REQ);
	assign mem_req_out.addr  = mem_addr_ff;

	// ----------------------------------------------------------------
	// transmitter load
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_char_ff   <= 8'h00;
			tx_strobe_ff <= 1'b0;
		end else begin
			if (state_ff == S_DECODE
				&& ctrl_byte_ff[line_tx_pkg::CB_SEND_DLE]) begin
				tx_char_ff <= protocol_ff[line_tx_pkg::PROTO_DLE_LO +: 8]; // [R9]
			end else if (state_ff == S_DNA) begin
				tx_char_ff <= memory_write_data_reg_ff;       // [R7] [R15]
			end
			tx_strobe_ff <= (nxt_state == S_STROBE)
				|| (nxt_state == S_DLE_STROBE);               // [R15]
		end
	end

	assign tx_load_out.strobe   = tx_strobe_ff;
	assign tx_load_out.char_val = tx_char_ff;
	assign busy_out             = (state_ff != S_IDLE);

	// ----------------------------------------------------------------
	// software registers and hardware updates
	// ----------------------------------------------------------------
	// counts and addresses: hardware advance wins over a write
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prin_addr_ff  <= line_tx_pkg::ZERO16;
			prin_count_ff <= line_tx_pkg::ZERO16;
			alt_addr_ff   <= line_tx_pkg::ZERO16;
			alt_count_ff  <= line_tx_pkg::ZERO16;
		end else if (state_ff == S_ADVANCE) begin
			if (sel_alt) begin                                // [R16]
				alt_count_ff <= inc_count;
				alt_addr_ff  <= alt_addr_ff + 16'h0001;
			end else begin
				prin_count_ff <= inc_count;
				prin_addr_ff  <= prin_addr_ff + 16'h0001;
			end
		end else if (wr_hit) begin
			case (reg_req_in.addr)
				line_tx_pkg::REG_PRIN_ADDR:  prin_addr_ff  <= reg_req_in.wdata;
				line_tx_pkg::REG_PRIN_COUNT: prin_count_ff <= reg_req_in.wdata;
				line_tx_pkg::REG_ALT_ADDR:   alt_addr_ff   <= reg_req_in.wdata;
				line_tx_pkg::REG_ALT_COUNT:  alt_count_ff  <= reg_req_in.wdata;
				default: ;
			endcase
		end
	end

	// control table base and protocol parameters
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_base_ff <= line_tx_pkg::ZERO16;
			protocol_ff  <= line_tx_pkg::ZERO16;
		end else if (wr_hit) begin
			if (reg_req_in.addr == line_tx_pkg::REG_CTRL_BASE) begin
				ctrl_base_ff <= reg_req_in.wdata;
			end
			if (reg_req_in.addr == line_tx_pkg::REG_PROTOCOL) begin
				protocol_ff <= reg_req_in.wdata;
			end
		end
	end

	// accumulated check: fold wins over a write
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			accum_check_ff <= line_tx_pkg::ZERO16;
		end else if (state_ff == S_ACCUM) begin
			accum_check_ff <= check_combine(accum_check_ff,
				memory_write_data_reg_ff,
				protocol_ff[line_tx_pkg::PROTO_CHK_LO +: 2]); // [R11]
		end else if (wr_hit
			&& reg_req_in.addr == line_tx_pkg::REG_ACCUM_CHECK) begin
			accum_check_ff <= reg_req_in.wdata;
		end
	end

	// mode bits and send-check-next progress bit
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_ff            <= line_tx_pkg::MODE_PLAIN;
			send_check_next_ff <= 1'b0;
		end else begin
			if (state_ff == S_CTRL_REQ && mem_done
				&& !mem_rsp_in.parity_err) begin
				mode_ff <= mem_rsp_in.data[line_tx_pkg::CB_MODE_LO +: 3]; // [R8]
			end else if (wr_hit
				&& reg_req_in.addr == line_tx_pkg::REG_MODE) begin
				mode_ff <= reg_req_in.wdata[2:0];
			end
			if (state_ff == S_DECODE
				&& ctrl_byte_ff[line_tx_pkg::CB_SEND_CHECK]) begin
				send_check_next_ff <= 1'b1;                   // [R10]
			end else if (wr_hit
				&& reg_req_in.addr == line_tx_pkg::REG_PROGRESS) begin
				send_check_next_ff <=
					reg_req_in.wdata[line_tx_pkg::PROG_SEND_CHECK];
			end
		end
	end

	// line state: hardware sets and clears win over a write
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			line_state_ff <= 8'h00;
		end else begin
			logic [7:0] ls;
			ls = line_state_ff;
			if (wr_hit && reg_req_in.addr == line_tx_pkg::REG_LINE_STATE) begin
				ls = reg_req_in.wdata[7:0];
			end
			// zero count on entry or after advance: switch or stop
			if ((state_ff == S_ENTRY && count_empty(sel_count))
				|| (state_ff == S_ADVANCE && count_empty(inc_count))) begin
				if (count_empty(other_count)) begin
					ls[line_tx_pkg::LS_GO] = 1'b0;            // [R1] [R17]
				end else begin
					ls[line_tx_pkg::LS_TABLE] = !sel_alt;     // [R1] [R17]
				end
			end
			if (state_ff == S_CTRL_REQ && mem_done
				&& mem_rsp_in.parity_err) begin
				ls[line_tx_pkg::LS_MPE] = 1'b1;
			end
			if (state_ff == S_CTRL_REQ && !mem_done && mem_timeout) begin
				ls[line_tx_pkg::LS_NXM] = 1'b1;               // [R18]
			end
			// an asynchronous line never reports starvation
			if (state_ff == S_DNA && data_not_available_in
				&& !async_line_in) begin
				ls[line_tx_pkg::LS_UNDERRUN] = 1'b1;          // [R12] [R13] [R14]
			end
			line_state_ff <= ls;
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	always_comb begin
		ev = 6'h00;
		ev[line_tx_pkg::EV_PRIN_ZERO] = ((state_ff == S_ENTRY
			&& count_empty(sel_count)) || (state_ff == S_ADVANCE
			&& count_empty(inc_count))) && !sel_alt;
		ev[line_tx_pkg::EV_ALT_ZERO]  = ((state_ff == S_ENTRY
			&& count_empty(sel_count)) || (state_ff == S_ADVANCE
			&& count_empty(inc_count))) && sel_alt;
		ev[line_tx_pkg::EV_CHAR_ERR]  = (state_ff == S_CHAR_REQ)
			&& ((mem_done && mem_rsp_in.parity_err)
			|| (!mem_done && mem_timeout));
		ev[line_tx_pkg::EV_CTRL_ERR]  = (state_ff == S_CTRL_REQ)
			&& ((mem_done && mem_rsp_in.parity_err)
			|| (!mem_done && mem_timeout));
		ev[line_tx_pkg::EV_UNDERRUN]  = (state_ff == S_DNA)
			&& data_not_available_in && !async_line_in;
		ev[line_tx_pkg::EV_END]       = line_state_ff[line_tx_pkg::LS_GO]
			&& ((state_ff == S_ENTRY && count_empty(sel_count))
			|| (state_ff == S_ADVANCE && count_empty(inc_count)))
			&& count_empty(other_count);
	end

	// sticky status, write one to clear, set wins; mask register
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			int_status_ff <= 6'h00;
			int_mask_ff   <= 6'h00;
		end else begin
			if (wr_hit && reg_req_in.addr == line_tx_pkg::REG_INT_STATUS) begin
				int_status_ff <= (int_status_ff & ~reg_req_in.wdata[5:0]) | ev;
			end else begin
				int_status_ff <= int_status_ff | ev;
			end
			if (wr_hit && reg_req_in.addr == line_tx_pkg::REG_INT_MASK) begin
				int_mask_ff <= reg_req_in.wdata[5:0];
			end
		end
	end

	assign irq_out = |(int_status_ff & int_mask_ff);

	// ----------------------------------------------------------------
	// read port, data one cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_ff <= 16'h0000;
		end else if (reg_req_in.rd) begin
			case (reg_req_in.addr)
				line_tx_pkg::REG_PRIN_ADDR:   rdata_ff <= prin_addr_ff;
				line_tx_pkg::REG_PRIN_COUNT:  rdata_ff <= prin_count_ff;
				line_tx_pkg::REG_ALT_ADDR:    rdata_ff <= alt_addr_ff;
				line_tx_pkg::REG_ALT_COUNT:   rdata_ff <= alt_count_ff;
				line_tx_pkg::REG_CTRL_BASE:   rdata_ff <= ctrl_base_ff;
				line_tx_pkg::REG_PROTOCOL:    rdata_ff <= protocol_ff;
				line_tx_pkg::REG_ACCUM_CHECK: rdata_ff <= accum_check_ff;
				line_tx_pkg::REG_MODE:        rdata_ff <= {13'h0000, mode_ff};
				line_tx_pkg::REG_PROGRESS:
					rdata_ff <= {15'h0000, send_check_next_ff};
				line_tx_pkg::REG_LINE_STATE:  rdata_ff <= {8'h00, line_state_ff};
				line_tx_pkg::REG_INT_STATUS:  rdata_ff <= {10'h000, int_status_ff};
				line_tx_pkg::REG_INT_MASK:    rdata_ff <= {10'h000, int_mask_ff};
				line_tx_pkg::REG_TX_CHAR:     rdata_ff <= {8'h00, tx_char_ff};
				default:                      rdata_ff <= 16'h0000;
			endcase
		end else begin
			rdata_ff <= 16'h0000;
		end
	end

	assign reg_rdata_out = rdata_ff;

endmodule : line_transmit_fetch_sequencer

// ### include/line_tx_pkg.sv
package line_tx_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int REG_AW = 4;
	localparam int MODE_W = 3;
	localparam int EV_W   = 6;
	localparam int CNT_W  = 12;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_PRIN_ADDR   = 4'h0;
	localparam logic [3:0] REG_PRIN_COUNT  = 4'h1;
	localparam logic [3:0] REG_ALT_ADDR    = 4'h2;
	localparam logic [3:0] REG_ALT_COUNT   = 4'h3;
	localparam logic [3:0] REG_CTRL_BASE   = 4'h4;
	localparam logic [3:0] REG_PROTOCOL    = 4'h5;
	localparam logic [3:0] REG_ACCUM_CHECK = 4'h6;
	localparam logic [3:0] REG_MODE        = 4'h7;
	localparam logic [3:0] REG_PROGRESS    = 4'h8;
	localparam logic [3:0] REG_LINE_STATE  = 4'h9;
	localparam logic [3:0] REG_INT_STATUS  = 4'hA;
	localparam logic [3:0] REG_INT_MASK    = 4'hB;
	localparam logic [3:0] REG_TX_CHAR     = 4'hC;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int LS_GO           = 2;
	localparam int LS_UNDERRUN     = 3;
	localparam int LS_NXM          = 4;
	localparam int LS_MPE          = 5;
	localparam int LS_TABLE        = 7;
	localparam int PROTO_CHK_LO    = 3;
	localparam int PROTO_MSG_TX    = 6;
	localparam int PROTO_DLE_LO    = 8;
	localparam int PROG_SEND_CHECK = 0;
	localparam int CB_SEND_DLE     = 1;
	localparam int CB_SEND_CHECK   = 2;
	localparam int CB_INCLUDE      = 3;
	localparam int CB_MODE_LO      = 5;
	localparam int COUNT_LOW_W     = 15;

	// interrupt event bits
	localparam int EV_PRIN_ZERO = 0;
	localparam int EV_ALT_ZERO  = 1;
	localparam int EV_CHAR_ERR  = 2;
	localparam int EV_CTRL_ERR  = 3;
	localparam int EV_UNDERRUN  = 4;
	localparam int EV_END       = 5;

	// ----------------------------------------------------------------
	// reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [15:0] ZERO16      = 16'h0000;
	localparam logic [2:0]  MODE_PLAIN  = 3'h0;
	localparam logic [1:0]  CHECK_LRC   = 2'h0;
	localparam logic [1:0]  CHECK_CRC16 = 2'h1;
	localparam logic [15:0] POLY_CRC16  = 16'hA001;
	localparam logic [15:0] POLY_CCITT  = 16'h8408;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int STROBE_NS      = 300;
	localparam int NXM_TIMEOUT_US = 20;
	localparam int STROBE_CYCLES  =
		(STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NXM_CYCLES     =
		(NXM_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [REG_AW-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
	} mem_req_t;

	typedef struct packed {
		logic       ack;
		logic       parity_err;
		logic [7:0] data;
	} mem_rsp_t;

	typedef struct packed {
		logic       strobe;
		logic [7:0] char_val;
	} tx_load_t;

endpackage : line_tx_pkg

// ### verif/line_tx_chk.sv
module line_tx_chk (
	// clock and reset
	input wire logic                   core_clk_in,
	input wire logic                   rst_n_in,
	// observed ports
	input wire line_tx_pkg::reg_req_t  reg_req_in,
	input wire logic [15:0]            reg_rdata_out,
	input wire line_tx_pkg::mem_req_t  mem_req_out,
	input wire line_tx_pkg::mem_rsp_t  mem_rsp_in,
	input wire line_tx_pkg::tx_load_t  tx_load_out,
	input wire logic                   busy_out
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NXM_MAX = 2001;
	logic [11:0] wait_ff;
	default clocking cb_chk @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// --------------------------------------------------------------
	// cycles waited on one read
	// --------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			wait_ff <= 12'h000;
		else if (mem_req_out.valid && !mem_rsp_in.ack)
			wait_ff <= wait_ff + 12'h001;
		else
			wait_ff <= 12'h000;
	end
	sequence s_hold; tx_load_out.strobe [*8]; endsequence
	sequence s_tail; ##22 tx_load_out.strobe ##1 !tx_load_out.strobe;
	endsequence
	property p_strobe_len;
		$rose(tx_load_out.strobe) |-> s_hold ##0 s_tail;
	endproperty
	a_strobe_len: assert property (p_strobe_len)
		else $error("strobe not 30 cycles");
	property p_char_stable;
		tx_load_out.strobe && $past(tx_load_out.strobe)
			|-> $stable(tx_load_out.char_val);
	endproperty
	a_char_stable: assert property (p_char_stable)
		else $error("char moved in strobe");
	property p_addr_hold;
		mem_req_out.valid && !mem_rsp_in.ack
			|=> !mem_req_out.valid || $stable(mem_req_out.addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("address moved before ack");
	property p_nxm_bound; wait_ff <= NXM_MAX; endproperty
	a_nxm_bound: assert property (p_nxm_bound)
		else $error("read wait too long");
	property p_err_idle;
		mem_req_out.valid && mem_rsp_in.ack && mem_rsp_in.parity_err
			|=> !mem_req_out.valid ##1 !tx_load_out.strobe;
	endproperty
	a_err_idle: assert property (p_err_idle)
		else $error("went on after parity error");
	property p_rd_idle;
		!$past(reg_req_in.rd) |-> reg_rdata_out == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside slot");
	property p_strobe_busy; tx_load_out.strobe |-> busy_out; endproperty
	a_strobe_busy: assert property (p_strobe_busy)
		else $error("strobe while idle");
	property p_valid_busy; mem_req_out.valid |-> busy_out; endproperty
	a_valid_busy: assert property (p_valid_busy)
		else $error("read while idle");
endmodule : line_tx_chk

bind line_transmit_fetch_sequencer line_tx_chk u_chk (
	.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
	.reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
	.mem_req_out(mem_req_out), .mem_rsp_in(mem_rsp_in),
	.tx_load_out(tx_load_out), .busy_out(busy_out));

// ### verif/host_mem_model.sv
module host_mem_model (
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rst_n_in,
	// read port and fault controls
	input  wire line_tx_pkg::mem_req_t req_in,
	input  wire logic [1:0]            lat_in,
	input  wire logic                  perr_in,
	input  wire logic                  dead_in,
	output line_tx_pkg::mem_rsp_t      rsp_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:4095];
	logic [1:0] cnt_ff;
	// answers a held read after lat_in cycles, data toggles off ack
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_ff <= 2'h0;
			rsp_out <= '0;
		end else begin
			rsp_out.ack <= 1'b0;
			rsp_out.parity_err <= 1'b0;
			rsp_out.data <= ~rsp_out.data;
			if (req_in.valid && !rsp_out.ack && !dead_in) begin
				cnt_ff <= cnt_ff + 2'h1;
				if (cnt_ff == lat_in) begin
					cnt_ff <= 2'h0;
					rsp_out <= {1'b1, perr_in, mem[req_in.addr[11:0]]};
				end
			end
		end
	end
endmodule : host_mem_model

// ### verif/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, svc, data_not_available, asy, dead, perr, busy, irq, sp;
	line_tx_pkg::reg_req_t req;
	line_tx_pkg::mem_req_t mreq;
	line_tx_pkg::mem_rsp_t mrsp;
	line_tx_pkg::tx_load_t tx;
	logic [15:0] rdat, acc, und, prg;
	logic [7:0] q[$], e[$], c, cb;
	logic [2:0] m;
	logic [1:0] lat;
	int miscompares, n_checks, seed, i, j, k;
	line_transmit_fetch_sequencer u_dut (.core_clk_in(clk),
		.rst_n_in(rst_n), .reg_req_in(req), .reg_rdata_out(rdat),
		.service_req_in(svc), .mem_req_out(mreq), .mem_rsp_in(mrsp),
		.data_not_available_in(data_not_available), .async_line_in(asy),
		.tx_load_out(tx), .busy_out(busy), .irq_out(irq));
	host_mem_model u_mem (.clk_in(clk), .rst_n_in(rst_n), .req_in(mreq),
		.lat_in(lat), .perr_in(perr), .dead_in(dead), .rsp_out(mrsp));
	initial begin clk = 1'b0; forever #5 clk = ~clk; end
	// collects each loaded character
	always @(posedge clk) begin
		if (tx.strobe && !sp) q.push_back(tx.char_val);
		sp <= tx.strobe;
	end
	task finish_test;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	task chk(input logic [15:0] g, input logic [15:0] x);
		n_checks++;
		if (g !== x) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask : chk
	task wr(input logic [3:0] ad, input logic [15:0] d);
		@(posedge clk) req <= {2'b10, ad, d};
		@(posedge clk) req <= '0;
	endtask : wr
	task rc(input logic [3:0] ad, input logic [15:0] mk, x);
		@(posedge clk) req <= {2'b01, ad, 16'h0000};
		@(posedge clk) req <= '0;
		#1 chk(rdat & mk, x);
	endtask : rc
	task pass;
		@(posedge clk) svc <= 1'b1;
		@(posedge clk) svc <= 1'b0;
		#1 k = 0;
		while (busy !== 1'b0 && k < 3000) begin @(posedge clk); #1 k++; end
		if (k >= 3000) begin miscompares++; finish_test; end
	endtask : pass
	task chk_q;
		chk(16'(q.size()), 16'(e.size()));
		for (j = 0; j < e.size(); j++) chk(q[j], e[j]);
		q.delete();
		e.delete();
	endtask : chk_q
	initial begin
		{rst_n, svc, data_not_available, asy, dead, perr, lat} = '0;
		req = '0;
		seed = 51215;
		{acc, und, prg, m} = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rc(4'hD, 16'hFFFF, 16'h0000);
		wr(4'hB, 16'h003F);
		wr(4'h9, 16'h0004);
		pass;
		chk_q;
		rc(4'h9, 16'h0004, 16'h0000);
		rc(4'hA, 16'h0020, 16'h0020);
		chk({15'h0, irq}, 16'h0001);
		wr(4'hA, 16'hFFFF);
		#1 chk({15'h0, irq}, 16'h0000);
		wr(4'h0, 16'h0100);
		wr(4'h1, 16'hFFFC);
		wr(4'h4, 16'h0200);
		wr(4'h5, 16'h1000);
		wr(4'h9, 16'h0004);
		for (i = 0; i < 4; i++) begin
			c = 8'($random(seed));
			cb = 8'($random(seed));
			{data_not_available, asy} <= 2'($random(seed));
			lat <= 2'($random(seed));
			u_mem.mem[12'h100 + i] = c;
			u_mem.mem[12'h200 + {m, c}] = cb;
			if (cb[1]) e.push_back(8'h10);
			e.push_back(c);
			if (cb[3]) acc = acc ^ c;
			m = cb[7:5];
			prg[0] = prg[0] | cb[2];
			pass;
			und[3] = und[3] | (data_not_available & !asy);
			chk_q;
			rc(4'h7, 16'hFFFF, {13'h0, m});
			rc(4'h6, 16'hFFFF, acc);
			rc(4'h8, 16'h0001, prg);
			rc(4'h9, 16'h0008, und);
			rc(4'h0, 16'hFFFF, 16'h0101 + i);
			rc(4'h1, 16'hFFFF, 16'hFFFD + i);
		end
		rc(4'h9, 16'h0004, 16'h0000);
		rc(4'hA, 16'h0021, 16'h0021);
		wr(4'h7, 16'h0000);
		wr(4'h5, 16'h1040);
		wr(4'h2, 16'h0300);
		wr(4'h3, 16'hFFFF);
		wr(4'h9, 16'h0004);
		c = 8'($random(seed));
		u_mem.mem[12'h300] = c;
		u_mem.mem[12'h200 + c] = 8'h02;
		acc = acc ^ c;
		e.push_back(c);
		pass;
		chk_q;
		rc(4'h6, 16'hFFFF, acc);
		rc(4'h9, 16'h0084, 16'h0080);
		rc(4'h2, 16'hFFFF, 16'h0301);
		rc(4'hA, 16'h0002, 16'h0002);
		perr <= 1'b1;
		wr(4'h1, 16'hFFFF);
		wr(4'h9, 16'h0004);
		pass;
		chk_q;
		rc(4'hA, 16'h0004, 16'h0004);
		rc(4'h1, 16'hFFFF, 16'hFFFF);
		perr <= 1'b0;
		dead <= 1'b1;
		pass;
		chk(16'(k >= 2000 && k < 2010), 16'h0001);
		chk_q;
		finish_test;
	end
endmodule : tb
